/* File: dma_bus_master_pin_control.sv */
// DMA bus-master pin control: hold handshake, address, acknowledge, memory strobes
// Function
// - Drive mid address outputs only in the active cycle, otherwise float them.
// - Raise hold request for an unmasked channel request or software request.
// - With hold request looped to grant, exactly one grant wait state precedes the first transfer after idle; chained transfers from done skip it.
// - One acknowledge per channel, programmable polarity, active low after reset.
// - Upper address gate is active high during DMA transfers.
// - Upper address strobe pulses; in block mode only on the first transfer after idle or when upper byte changes.
// - Active-low memory read strobe on DMA read and memory-to-memory read phase.
// - Active-low memory write strobe on DMA write and memory-to-memory write phase.
// - Fixed priority: channel zero first, channel three last.
// - Lowest four address lines carry low address bits in the active cycle.
`default_nettype none
module dma_bus_master_pin_control
  import dma_pin_pkg::*;
#(
  parameter int NUM_CH = CHANNELS
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  input wire logic [NUM_CH-1:0] channel_request_in,
  input wire logic [NUM_CH-1:0] channel_mask_in,
  input wire logic [NUM_CH-1:0] software_request_in,
  input wire logic [NUM_CH-1:0] ack_active_high_in,
  input wire logic bus_hold_grant_in,
  input wire xfer_setup_t [NUM_CH-1:0] setup_in,
  output logic bus_hold_request_out,
  output logic [NUM_CH-1:0] channel_acknowledge_out,
  output logic upper_address_gate_out,
  output logic upper_address_strobe_out,
  output address_pins_t address_pins_out,
  output logic memory_read_strobe_n_out,
  output logic memory_read_strobe_oe_n_out,
  output logic memory_write_strobe_n_out,
  output logic memory_write_strobe_oe_n_out,
  output logic [NUM_CH-1:0] channel_done_out
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_GRANT_WAIT,
    ST_ADDR_UPDATE,
    ST_READ,
    ST_WRITE,
    ST_DONE
  } state_t;

  state_t state_reg;
  logic [NUM_CH-1:0] req_sync;
  logic grant_sync;
  logic active;
  logic in_xfer;
  logic [NUM_CH-1:0] pending;
  logic [1:0] sel_reg;
  logic [NUM_CH-1:0] ack_level_reg;
  logic [7:0] last_upper_reg;
  logic upper_valid_reg;
  logic [1:0] phase_cnt_reg;
  xfer_setup_t cur;

  pin_sync #(.WIDTH(NUM_CH)) req_sync_i (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .clk_en_in(clk_en_in),
    .async_in(channel_request_in),
    .sync_out(req_sync)
  );

  pin_sync #(.WIDTH(1)) grant_sync_i (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .clk_en_in(clk_en_in),
    .async_in(bus_hold_grant_in),
    .sync_out(grant_sync)
  );

  // Lowest index wins
  function automatic logic [1:0] pick_channel(input logic [NUM_CH-1:0] req);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  assign pending = (req_sync & ~channel_mask_in) | software_request_in;
  assign cur = setup_in[sel_reg];
  assign active = state_reg inside {ST_ADDR_UPDATE, ST_READ, ST_WRITE};
  assign in_xfer = state_reg inside {ST_READ, ST_WRITE};

  // Acknowledge sense sampled on every enabled clock while the sequencer is idle
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_level_reg <= ACK_LEVEL_RESET;
    end else if (clk_en_in && state_reg == ST_IDLE) begin
      ack_level_reg <= ack_active_high_in;
    end
  end

  // Transfer sequencer
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= ST_IDLE;
      sel_reg <= 2'h0;
      phase_cnt_reg <= 2'h0;
    end else if (clk_en_in) begin
      case (state_reg)
        ST_IDLE: begin
          if (|pending) begin
            sel_reg <= pick_channel(pending);
            // A grant left over from the last tenure is not taken as a new one
            if (!grant_sync) begin
              state_reg <= ST_GRANT_WAIT;
            end
          end
        end
        ST_GRANT_WAIT: begin
          if (grant_sync) begin
            sel_reg <= pick_channel(pending);
            state_reg <= ST_ADDR_UPDATE;
          end else if (!(|pending)) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_ADDR_UPDATE: begin
          phase_cnt_reg <= 2'h0;
          state_reg <= (cur.kind == XFER_IO_TO_MEM) ? ST_WRITE : ST_READ;
        end
        ST_READ: begin
          phase_cnt_reg <= phase_cnt_reg + 2'h1;
          if (phase_cnt_reg == 2'(XFER_CYCLES - 1)) begin
            phase_cnt_reg <= 2'h0;
            state_reg <= (cur.kind == XFER_MEM_TO_MEM) ? ST_WRITE : ST_DONE;
          end
        end
        ST_WRITE: begin
          phase_cnt_reg <= phase_cnt_reg + 2'h1;
          if (phase_cnt_reg == 2'(XFER_CYCLES - 1)) begin
            phase_cnt_reg <= 2'h0;
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (|pending && grant_sync) begin
            sel_reg <= pick_channel(pending);
            state_reg <= ST_ADDR_UPDATE;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Upper byte tracking for strobe suppression in block mode
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      last_upper_reg <= 8'h00;
      upper_valid_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (state_reg == ST_ADDR_UPDATE) begin
        last_upper_reg <= cur.address[15:8];
        upper_valid_reg <= 1'b1;
      end else if (state_reg == ST_IDLE) begin
        upper_valid_reg <= 1'b0;
      end
    end
  end

  // Pin outputs, all registered
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bus_hold_request_out <= 1'b0;
      channel_acknowledge_out <= ~ACK_LEVEL_RESET;
      upper_address_gate_out <= 1'b0;
      upper_address_strobe_out <= 1'b0;
      address_pins_out <= '{default: '0, low_address_oe_n: 4'hf,
                            mid_address_oe_n: 4'hf, upper_byte_oe_n: 8'hff};
      memory_read_strobe_n_out <= 1'b1;
      memory_read_strobe_oe_n_out <= 1'b1;
      memory_write_strobe_n_out <= 1'b1;
      memory_write_strobe_oe_n_out <= 1'b1;
      channel_done_out <= '0;
    end else if (clk_en_in) begin
      bus_hold_request_out <= (state_reg != ST_IDLE) ? (|pending || active)
                                                      : |pending;
      upper_address_gate_out <= active;
      upper_address_strobe_out <= (state_reg == ST_ADDR_UPDATE) &&
        (!cur.block_mode || !upper_valid_reg ||
         cur.address[15:8] != last_upper_reg);
      address_pins_out.low_address <= cur.address[3:0];
      address_pins_out.low_address_oe_n <= active ? 4'h0 : 4'hf;
      address_pins_out.mid_address <= cur.address[7:4];
      address_pins_out.mid_address_oe_n <= active ? 4'h0 : 4'hf;
      address_pins_out.upper_byte <= cur.address[15:8];
      address_pins_out.upper_byte_oe_n <= (state_reg == ST_ADDR_UPDATE) ? 8'h00 : 8'hff;
      for (int i = 0; i < NUM_CH; i++) begin
        channel_acknowledge_out[i] <= (in_xfer && sel_reg == 2'(i)) ? ack_level_reg[i]
                                                                     : ~ack_level_reg[i];
        channel_done_out[i] <= (state_reg == ST_DONE) && sel_reg == 2'(i);
      end
      memory_read_strobe_n_out <= !(state_reg == ST_READ &&
        cur.kind inside {XFER_MEM_TO_IO, XFER_MEM_TO_MEM});
      memory_write_strobe_n_out <= !(state_reg == ST_WRITE &&
        cur.kind inside {XFER_IO_TO_MEM, XFER_MEM_TO_MEM});
      memory_read_strobe_oe_n_out <= !active;
      memory_write_strobe_oe_n_out <= !active;
    end
  end

  // Checks
  property p_gate_follows;
    @(posedge clk_in) disable iff (!nrst_in)
      clk_en_in && state_reg == ST_READ |=> upper_address_gate_out;
  endproperty
  gate_when_active_a: assert property (p_gate_follows)
    else $error("address gate low during transfer");

  no_hold_idle_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    clk_en_in && state_reg == ST_IDLE && !(|pending) |=> !bus_hold_request_out)
    else $error("hold request without pending request");

  hold_on_request_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    clk_en_in && |pending |=> bus_hold_request_out)
    else $error("hold request missing");

  mid_float_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    clk_en_in && state_reg == ST_IDLE |=> address_pins_out.mid_address_oe_n == 4'hf)
    else $error("mid address driven outside active cycle");

  low_addr_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    clk_en_in && state_reg == ST_READ |=> address_pins_out.low_address_oe_n == 4'h0)
    else $error("low address not driven in active cycle");

  sequence s_wait;
    state_reg == ST_GRANT_WAIT && grant_sync && clk_en_in;
  endsequence
  one_wait_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_wait |=> state_reg == ST_ADDR_UPDATE)
    else $error("grant wait not left after grant");

  read_strobe_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !memory_read_strobe_n_out |-> !memory_read_strobe_oe_n_out)
    else $error("read strobe low while floated");

  write_strobe_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !memory_write_strobe_n_out |-> !memory_write_strobe_oe_n_out)
    else $error("write strobe low while floated");

  priority_pick_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    clk_en_in && state_reg == ST_IDLE && pending[0] |=> sel_reg == 2'h0)
    else $error("channel zero not chosen first");

  ack_reset_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    clk_en_in && state_reg == ST_IDLE && ack_level_reg == 4'h0
    |=> channel_acknowledge_out == 4'hf)
    else $error("acknowledge active while idle");
endmodule
`default_nettype wire

/* File: dma_pin_pkg.sv */
// Package: constants and carriers for the DMA bus-master pin control
`default_nettype none
package dma_pin_pkg;
  localparam int CHANNELS = 4;
  localparam logic [3:0] MASK_RESET = 4'hf;
  localparam logic [3:0] ACK_LEVEL_RESET = 4'h0;
  localparam int SYNC_STAGES = 2;
  localparam int XFER_CYCLES = 2;

  typedef enum logic [1:0] {
    XFER_IO_TO_MEM,
    XFER_MEM_TO_IO,
    XFER_MEM_TO_MEM,
    XFER_VERIFY
  } xfer_kind_t;

  typedef struct packed {
    logic [15:0] address;
    xfer_kind_t kind;
    logic block_mode;
  } xfer_setup_t;

  typedef struct packed {
    logic [3:0] low_address;
    logic [3:0] low_address_oe_n;
    logic [3:0] mid_address;
    logic [3:0] mid_address_oe_n;
    logic [7:0] upper_byte;
    logic [7:0] upper_byte_oe_n;
  } address_pins_t;
endpackage
`default_nettype wire

/* File: pin_sync.sv */
// Two-flop synchroniser for a bus of pin inputs
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_reg;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stage_reg <= '0;
      sync_out <= '0;
    end else if (clk_en_in) begin
      stage_reg <= async_in;
      sync_out <= stage_reg;
    end
  end
endmodule
`default_nettype wire

/* File: host_bus_arbiter.sv */
// Host bus arbiter model: grants the hold after its own buses are off
`default_nettype none
module host_bus_arbiter (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic req_in,
  input wire logic loop_in,
  input wire logic [3:0] delay_in,
  output logic grant_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_reg;
  logic grant_reg;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wait_reg <= 4'h0;
      grant_reg <= 1'b0;
    end else if (!req_in) begin
      wait_reg <= 4'h0;
      grant_reg <= 1'b0;
    end else if (wait_reg == delay_in) begin
      grant_reg <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
  // Stand-alone use ties request straight to grant
  assign grant_out = loop_in ? req_in : grant_reg;
endmodule
`default_nettype wire

/* File: dma_bus_master_pin_control_tb.sv */
// Testbench for the DMA bus-master pin control
`default_nettype none
module dma_bus_master_pin_control_tb;
  import dma_pin_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, nrst_in, loop, grant, hold, gate, stb, rd_n, rd_oe_n, wr_n, wr_oe_n;
  logic [3:0] channel_request, mask, sw, sense, dly, ack, done, acc_ack;
  xfer_setup_t [3:0] setup;
  address_pins_t pins;
  logic [26:0] exp_q[$];
  logic acc_rd, acc_wr, acc_stb;
  logic [7:0] acc_adr, acc_up;
  int n_errors, tests_run, cycles, c, lat;

  dma_bus_master_pin_control dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .clk_en_in(1'b1),
    .channel_request_in(channel_request), .channel_mask_in(mask), .software_request_in(sw),
    .ack_active_high_in(sense), .bus_hold_grant_in(grant), .setup_in(setup),
    .bus_hold_request_out(hold), .channel_acknowledge_out(ack),
    .upper_address_gate_out(gate), .upper_address_strobe_out(stb),
    .address_pins_out(pins), .memory_read_strobe_n_out(rd_n),
    .memory_read_strobe_oe_n_out(rd_oe_n), .memory_write_strobe_n_out(wr_n),
    .memory_write_strobe_oe_n_out(wr_oe_n), .channel_done_out(done));
  host_bus_arbiter host_u (.clk_in(clk_in), .nrst_in(nrst_in), .req_in(hold),
    .loop_in(loop), .delay_in(dly), .grant_out(grant));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic chk(input string what, input logic [26:0] e, input logic [26:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task complete_run;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  // Record: latched upper byte, done, active acks, read, write, strobe, low address byte
  function automatic logic [26:0] exp_of(input int ch, input logic s);
    xfer_kind_t k;
    k = setup[ch].kind;
    exp_of = {setup[ch].address[15:8], 4'h1 << ch, 4'h1 << ch,
      k == XFER_MEM_TO_IO || k == XFER_MEM_TO_MEM,
      k == XFER_IO_TO_MEM || k == XFER_MEM_TO_MEM, s, setup[ch].address[7:0]};
  endfunction

  // Collects what one transfer shows at the pins, judged at its done pulse
  always @(posedge clk_in) begin
    logic [3:0] act;
    logic [26:0] exp_v, got;
    act = (ack ~^ sense) & {4{gate}};
    if (nrst_in) begin
      if (act != 4'h0 && acc_ack == 4'h0) begin
        acc_adr = (pins.mid_address_oe_n | pins.low_address_oe_n) == 4'h0 ?
          {pins.mid_address, pins.low_address} : 8'hxx;
      end
      acc_ack = acc_ack | act;
      acc_rd = acc_rd | (!rd_n && !rd_oe_n);
      acc_wr = acc_wr | (!wr_n && !wr_oe_n);
      acc_stb = acc_stb | stb;
      // Models the external latch that takes the upper byte on the strobe
      if (stb) begin
        acc_up = pins.upper_byte_oe_n == 8'h00 ? pins.upper_byte : 8'hxx;
      end
      // Looped grant: two sync flops, one grant wait state, one address state
      if (!hold) begin
        lat = 0;
      end else if (!gate) begin
        lat++;
      end else if (lat != 0) begin
        if (loop) chk("grant wait", 27'(SYNC_STAGES + 2), 27'(lat));
        lat = 0;
      end
      if (done != 4'h0) begin
        exp_v = exp_q.size() > 0 ? exp_q.pop_front() : 27'hx;
        got = {acc_up, done, acc_ack, acc_rd, acc_wr, acc_stb, acc_adr};
        chk("transfer", exp_v, got);
        acc_ack = 4'h0;
        {acc_rd, acc_wr, acc_stb} = 3'h0;
      end
    end
  end

  // Peripheral side: a request is withdrawn once its acknowledge is seen
  task automatic run(input logic [3:0] s, input logic [3:0] p);
    logic [3:0] act;
    sw = s;
    channel_request = p;
    for (int i = 0; i < 300 && (sw | channel_request | {3'h0, hold}) != 4'h0; i++) begin
      @(negedge clk_in);
      act = (ack ~^ sense) & {4{gate}};
      sw = sw & ~act;
      channel_request = channel_request & ~act;
    end
    repeat (2) @(negedge clk_in);
    chk("idle", 27'h3f, {19'h0, hold, gate, pins.mid_address_oe_n, rd_oe_n, wr_oe_n});
  endtask

  initial begin
    {nrst_in, loop, channel_request, mask, sw, sense, acc_ack} = '0;
    {acc_rd, acc_wr, acc_stb, acc_adr, acc_up} = '0;
    lat = 0;
    dly = 4'h2;
    setup = '0;
    n_errors = 0;
    tests_run = 0;
    cycles = 0;
    void'($urandom(9127));
    repeat (8) @(negedge clk_in);
    nrst_in = 1'b1;
    @(negedge clk_in);
    for (c = 0; c < 4; c++) begin
      setup[c] = '{address: 16'($urandom), kind: xfer_kind_t'(c), block_mode: 1'b0};
      sense = 4'($urandom);
      dly = 4'($urandom % 6);
      exp_q.push_back(exp_of(c, 1'b1));
      run(4'h1 << c, 4'h0);
    end
    for (c = 0; c < 4; c++) exp_q.push_back(exp_of(c, 1'b1));
    run(4'hf, 4'h0);
    mask = 4'h8;
    setup[3].kind = XFER_MEM_TO_MEM;
    channel_request = 4'h8;
    repeat (12) @(negedge clk_in);
    chk("masked hold", 27'h0, {26'h0, hold});
    mask = 4'h0;
    exp_q.push_back(exp_of(3, 1'b1));
    run(4'h0, 4'h8);
    setup[1].block_mode = 1'b1;
    setup[2].block_mode = 1'b1;
    setup[2].address[15:8] = setup[1].address[15:8];
    exp_q.push_back(exp_of(1, 1'b1));
    exp_q.push_back(exp_of(2, 1'b0));
    run(4'h6, 4'h0);
    loop = 1'b1;
    exp_q.push_back(exp_of(0, 1'b1));
    run(4'h1, 4'h0);
    repeat (4) @(negedge clk_in);
    chk("pending", 27'h0, 27'(exp_q.size()));
    complete_run();
  end
endmodule
`default_nettype wire
